//--- src/setpoint_limit_regs.sv
// Overview of operation
// - Targets above upper limit clamp to limit while conversion is enabled.
// - Clamp sets warning, status bits, alerts host.
// - Limit written below target clamps likewise.
// - Margin high targets margin high plus offset.
// - Margin low targets margin low plus offset.
// - Margin transitions ramp at programmed slew rate.
// - Margin high plus offset checked against limit.
// - Out-of-range margin or slew writes flag invalid.
// - Slew rate applies only during normal conversion.
// - Slew register: exponent fixed at reset, mantissa from memory.
// - Slew values read back unchanged; decoded value rounded down applied.
// - Slew range 0.067 to 15.933 mV/us only.
// - Divider scale selects the feedback resistor divider.
// - Divider update blocked while conversion runs.
// - Divider register linear, exponent resets 11001b.
// - Upper limit is 16-bit unsigned, memory reset.
// - Margin levels are 16-bit unsigned, memory reset.
// - Offset added to active setpoint before checks.
`timescale 1ns/10ps
`include "setpoint_regs_defines.svh"

module setpoint_limit_regs #(
    parameter int TICK_CYCLES = `SLEW_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input setpoint_regs_pkg::cmd_req_t cmd,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_error,
    input wire logic conversion_enable,
    input wire logic turn_ramp_active,
    input wire logic [1:0] margin_select,
    input wire logic [15:0] nominal_setpoint,
    input wire logic [15:0] setpoint_offset,
    input wire logic clear_faults,
    input wire logic restore_user_all,
    input wire logic supply_uvlo_cycle,
    input setpoint_regs_pkg::nvm_defaults_t nvm,
    output logic [15:0] output_target,
    output logic output_slewing,
    output setpoint_regs_pkg::div_setting_t divider_setting,
    output setpoint_regs_pkg::status_flags_t status,
    output logic host_alert
);
    import setpoint_regs_pkg::*;

    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_check
        $error("setpoint_limit_regs: tick period not supported");
    end

    // Decoded slew rate in 1/16 mV/us, saturated to 16 bits.
    function automatic logic [15:0] slew_units(input logic [15:0] word);
        int e;
        int m;
        int v;
        e = $signed(word[`LIN_EXP_MSB:`LIN_EXP_LSB]) + `SLEW_BASE_EXP;
        m = $signed(word[`LIN_MAN_MSB:`LIN_MAN_LSB]);
        v = 0;
        if (m <= 0) begin
            v = 0;
        end else if (e >= 16) begin
            v = 65535;
        end else if (e >= 0) begin
            v = m << e;
        end else if (e > -16) begin
            v = m >>> (-e);
        end
        if (v > 65535) begin
            v = 65535;
        end
        return 16'(v);
    endfunction : slew_units

    // Divider decode: smallest supported scaling factor at or above a linear word.
    function automatic div_setting_t divider_decode(input logic [15:0] word);
        int e;
        int m;
        longint v;
        e = $signed(word[`LIN_EXP_MSB:`LIN_EXP_LSB]) + `DIV_SCALE_FRAC;
        m = $signed(word[`LIN_MAN_MSB:`LIN_MAN_LSB]);
        v = (e >= 0) ? (longint'(m) <<< e) : (longint'(m) >>> (-e));
        if (v <= `DIV_THRESH_EIGHTH) begin
            return div_1to7;
        end else if (v <= `DIV_THRESH_QUARTER) begin
            return div_1to3;
        end else if (v <= `DIV_THRESH_HALF) begin
            return div_1to1;
        end
        return div_none;
    endfunction : divider_decode

    // Highest target code the reference can serve for a divider setting.
    function automatic logic [15:0] valid_max(input div_setting_t d);
        unique case (d)
            div_none: return `VALID_MAX_DIV_NONE;
            div_1to1: return `VALID_MAX_DIV_1TO1;
            div_1to3: return `VALID_MAX_DIV_1TO3;
            div_1to7: return `VALID_MAX_DIV_1TO7;
        endcase
    endfunction : valid_max

    // Level plus signed offset, kept wide so a negative sum stays visible.
    function automatic logic signed [17:0] add_offset(input logic [15:0] level,
                                                      input logic [15:0] offs);
        return $signed({2'b00, level}) + $signed({{2{offs[15]}}, offs});
    endfunction : add_offset

    // Register storage; the five command registers are word wide.
    logic [15:0] upper_limit_q; // Upper output limit code.
    logic [15:0] margin_high_q; // Margin high level.
    logic [15:0] margin_low_q; // Margin low level.
    logic [15:0] slew_word_q; // Slew register exactly as written.
    logic [15:0] divider_word_q; // Divider register exactly as written.
    div_setting_t divider_q; // Divider setting applied to hardware.
    status_flags_t status_q; // Sticky status flags.
    logic [15:0] tick_cnt_q; // Microsecond divider.
    logic tick_q; // One-cycle microsecond enable.
    logic over_q; // Clamp condition seen last cycle.
    logic signed [17:0] raw_q; // Unclamped target of last cycle.
    logic [15:0] target_q; // Registered clamped target for the ramp.
    logic rsp_valid_q;
    logic [15:0] rsp_data_q;
    logic rsp_error_q;
    logic alert_q;

    // Decoded write strobes and write-data checks.
    logic wr;
    logic rd;
    logic wr_limit;
    logic wr_mhigh;
    logic wr_mlow;
    logic wr_slew;
    logic wr_div;
    logic known_code;
    logic [15:0] slew_req;
    logic slew_ok;
    logic mhigh_ok;
    logic mlow_ok;
    logic bad_write;
    logic signed [17:0] mhigh_sum;
    logic signed [17:0] mlow_sum;
    logic [15:0] cur_max;
    logic signed [17:0] raw_d;
    logic over_d;
    logic [15:0] target_d;
    logic clamp_event;
    logic [15:0] slew_now;
    logic [7:0] ramp_rate;
    logic [15:0] ramp_level;
    logic ramp_moving;
    logic reload;

    assign wr = cmd.valid && cmd.write;
    assign rd = cmd.valid && !cmd.write;
    assign reload = srst || restore_user_all;
    assign known_code = (cmd.code == `CMD_OUTPUT_UPPER_LIMIT) ||
                        (cmd.code == `CMD_MARGIN_HIGH_LEVEL) ||
                        (cmd.code == `CMD_MARGIN_LOW_LEVEL) ||
                        (cmd.code == `CMD_SETPOINT_SLEW_RATE) ||
                        (cmd.code == `CMD_FEEDBACK_DIVIDER_SCALE);
    assign cur_max = valid_max(divider_q);

    // A slew write is valid only when it decodes inside the range.
    assign slew_req = slew_units(cmd.data);
    assign slew_ok = (32'(slew_req) * `SLEW_UNIT_TENTH_UV >= `SLEW_MIN_UV_PER_US * 10) &&
                     (32'(slew_req) * `SLEW_UNIT_TENTH_UV <= `SLEW_MAX_UV_PER_US * 10);

    // Margin levels are checked with the offset included.
    assign mhigh_sum = add_offset(cmd.data, setpoint_offset);
    assign mlow_sum = add_offset(cmd.data, setpoint_offset);
    assign mhigh_ok = (mhigh_sum >= 0) && (mhigh_sum <= $signed({2'b00, upper_limit_q})) &&
                      (mhigh_sum <= $signed({2'b00, cur_max}));
    assign mlow_ok = (mlow_sum >= 0) && (mlow_sum <= $signed({2'b00, cur_max}));

    assign wr_limit = wr && cmd.code == `CMD_OUTPUT_UPPER_LIMIT;
    assign wr_mhigh = wr && cmd.code == `CMD_MARGIN_HIGH_LEVEL && mhigh_ok;
    assign wr_mlow = wr && cmd.code == `CMD_MARGIN_LOW_LEVEL && mlow_ok;
    assign wr_slew = wr && cmd.code == `CMD_SETPOINT_SLEW_RATE && slew_ok;
    assign wr_div = wr && cmd.code == `CMD_FEEDBACK_DIVIDER_SCALE;
    assign bad_write = wr && ((cmd.code == `CMD_MARGIN_HIGH_LEVEL && !mhigh_ok) ||
                              (cmd.code == `CMD_MARGIN_LOW_LEVEL && !mlow_ok) ||
                              (cmd.code == `CMD_SETPOINT_SLEW_RATE && !slew_ok));

    // Upper limit: full 16-bit word, reloaded from memory.
    always_ff @(posedge sys_clk) begin
        if (reload) begin
            upper_limit_q <= nvm.upper_limit;
        end else if (wr_limit) begin
            upper_limit_q <= cmd.data;
        end
    end

    // Margin levels: rejected writes leave the old value in place.
    always_ff @(posedge sys_clk) begin
        if (reload) begin
            margin_high_q <= nvm.margin_high;
            margin_low_q <= nvm.margin_low;
        end else begin
            if (wr_mhigh) begin
                margin_high_q <= cmd.data;
            end
            if (wr_mlow) begin
                margin_low_q <= cmd.data;
            end
        end
    end

    // Slew word is stored verbatim; the decode happens on use.
    always_ff @(posedge sys_clk) begin
        if (reload) begin
            slew_word_q <= {`SLEW_EXP_RESET, nvm.slew_mantissa};
        end else if (wr_slew) begin
            slew_word_q <= cmd.data;
        end
    end

    // Divider word is always stored; software may read it back at once.
    always_ff @(posedge sys_clk) begin
        if (reload) begin
            divider_word_q <= {`DIVIDER_EXP_RESET, nvm.divider_mantissa};
        end else if (wr_div) begin
            divider_word_q <= cmd.data;
        end
    end

    // Hardware divider follows writes only while idle, else waits for a
    // supply cycle (a restore loads the memory value instead), because
    // switching it mid-conversion would step the regulated output.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divider_q <= divider_decode({`DIVIDER_EXP_RESET, nvm.divider_mantissa});
        end else if (wr_div && !conversion_enable) begin
            divider_q <= divider_decode(cmd.data);
        end else if (restore_user_all) begin
            divider_q <= divider_decode({`DIVIDER_EXP_RESET, nvm.divider_mantissa});
        end else if (supply_uvlo_cycle) begin
            divider_q <= divider_decode(divider_word_q);
        end
    end

    assign divider_setting = divider_q;

    // Target selection: active setpoint plus offset, then limit checks.
    always_comb begin
        unique case (margin_select)
            `MARGIN_SEL_HIGH: raw_d = add_offset(margin_high_q, setpoint_offset);
            `MARGIN_SEL_LOW: raw_d = add_offset(margin_low_q, setpoint_offset);
            default: raw_d = add_offset(nominal_setpoint, setpoint_offset);
        endcase
    end

    // Over-limit only counts while conversion is running.
    assign over_d = conversion_enable && (raw_d > $signed({2'b00, upper_limit_q}));

    // Clamp to the limit, then silently to what the reference can serve.
    always_comb begin
        if (over_d) begin
            target_d = upper_limit_q;
        end else if (raw_d < 0) begin
            target_d = 16'h0000;
        end else if (raw_d > $signed({2'b00, 16'hFFFF})) begin
            target_d = 16'hFFFF;
        end else begin
            target_d = raw_d[15:0];
        end
        if (target_d > cur_max) begin
            target_d = cur_max;
        end
    end

    // A clamp event is a new over-limit target or a limit write under it.
    assign clamp_event = over_d && (!over_q || raw_d != raw_q || wr_limit);

    // Registered target and clamp history.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            target_q <= '0;
            raw_q <= '0;
            over_q <= 1'b0;
        end else begin
            target_q <= target_d;
            raw_q <= raw_d;
            over_q <= over_d;
        end
    end

    // Sticky status: a new event in the clear cycle wins over the clear.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_q <= '0;
        end else begin
            if (clear_faults) begin
                status_q <= '0;
            end
            if (clamp_event) begin
                status_q.limit_clamp_warning <= 1'b1;
                status_q.none_of_the_above <= 1'b1;
                status_q.word_output_voltage <= 1'b1;
            end
            if (bad_write) begin
                status_q.invalid_data <= 1'b1;
            end
            if (cmd.valid && !known_code) begin
                status_q.unsupported_command <= 1'b1;
            end
        end
    end

    // Host alert tracks the sticky flags; it falls when they are cleared.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alert_q <= 1'b0;
        end else if (clamp_event || bad_write || (cmd.valid && !known_code)) begin
            alert_q <= 1'b1;
        end else if (clear_faults) begin
            alert_q <= 1'b0;
        end
    end

    // Read and write answers come one cycle after the request.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
            rsp_error_q <= 1'b0;
        end else begin
            rsp_valid_q <= cmd.valid;
            rsp_error_q <= cmd.valid && (!known_code || bad_write);
            rsp_data_q <= '0;
            if (rd) begin
                unique case (cmd.code)
                    `CMD_OUTPUT_UPPER_LIMIT: rsp_data_q <= upper_limit_q;
                    `CMD_MARGIN_HIGH_LEVEL: rsp_data_q <= margin_high_q;
                    `CMD_MARGIN_LOW_LEVEL: rsp_data_q <= margin_low_q;
                    `CMD_SETPOINT_SLEW_RATE: rsp_data_q <= slew_word_q;
                    `CMD_FEEDBACK_DIVIDER_SCALE: rsp_data_q <= divider_word_q;
                    default: rsp_data_q <= '0;
                endcase
            end
        end
    end

    // Microsecond enable for the slew accumulator.
    always_ff @(posedge sys_clk) begin
        if (srst || tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == 16'(TICK_CYCLES - 1));
        end
    end

    // Written slew words are in range; a larger word from memory saturates to eight bits.
    assign slew_now = slew_units(slew_word_q);
    assign ramp_rate = (slew_now > 16'h00FF) ? 8'hFF : slew_now[7:0];

    // The ramp applies the programmed rate; turn-on and turn-off bypass it.
    setpoint_ramp #(
        .RATE_W(8)
    ) u_ramp (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(tick_q),
        .rate(ramp_rate),
        .bypass(turn_ramp_active || !conversion_enable),
        .target(target_q),
        .level(ramp_level),
        .moving(ramp_moving)
    );

    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_error = rsp_error_q;
    assign output_target = ramp_level;
    assign output_slewing = ramp_moving;
    assign status = status_q;
    assign host_alert = alert_q;

endmodule : setpoint_limit_regs

//--- src/setpoint_ramp.sv
`timescale 1ns/10ps
`include "setpoint_regs_defines.svh"

module setpoint_ramp #(
    parameter int RATE_W = 8,
    parameter int STEP_UNITS = (`VOUT_LSB_UV * 16) / 1000
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic [RATE_W-1:0] rate,
    input wire logic bypass,
    input wire logic [15:0] target,
    output logic [15:0] level,
    output logic moving
);

    // Accumulator of slew credit in 1/16 mV units.
    logic [RATE_W+2:0] credit_q;
    logic [15:0] level_q;
    logic step_ok;

    if (STEP_UNITS < 1 || RATE_W < 4) begin : g_check
        $error("setpoint_ramp: step size or rate width not supported");
    end

    // A step is due once a whole code worth of credit has built up.
    assign step_ok = (credit_q >= (RATE_W + 3)'(STEP_UNITS));

    // Credit grows each microsecond and is spent one code per cycle.
    always_ff @(posedge sys_clk) begin
        if (srst || bypass || level_q == target) begin
            credit_q <= '0;
        end else if (step_ok) begin
            credit_q <= credit_q - (RATE_W + 3)'(STEP_UNITS);
        end else if (tick) begin
            // Saturate so a stalled ramp cannot wrap its credit.
            if (credit_q[RATE_W+2:RATE_W+1] == 2'b11) begin
                credit_q <= credit_q;
            end else begin
                credit_q <= credit_q + (RATE_W + 3)'(rate);
            end
        end
    end

    // The level follows the target; turn-on and turn-off ramps jump.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            level_q <= '0;
        end else if (bypass) begin
            level_q <= target;
        end else if (step_ok && level_q < target) begin
            level_q <= level_q + 16'h0001;
        end else if (step_ok && level_q > target) begin
            level_q <= level_q - 16'h0001;
        end
    end

    assign level = level_q;

    // Moving flag is registered, so it lags the level by one cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            moving <= 1'b0;
        end else begin
            moving <= !bypass && (level_q != target);
        end
    end

endmodule : setpoint_ramp

//--- src/setpoint_regs_defines.svh
`ifndef SETPOINT_REGS_DEFINES_SVH
`define SETPOINT_REGS_DEFINES_SVH

// Command codes of the word registers held by this bank.
`define CMD_OUTPUT_UPPER_LIMIT 8'h24
`define CMD_MARGIN_HIGH_LEVEL 8'h25
`define CMD_MARGIN_LOW_LEVEL 8'h26
`define CMD_SETPOINT_SLEW_RATE 8'h27
`define CMD_FEEDBACK_DIVIDER_SCALE 8'h29

// Linear format field positions shared by slew and divider registers.
`define LIN_EXP_MSB 15
`define LIN_EXP_LSB 11
`define LIN_MAN_MSB 10
`define LIN_MAN_LSB 0

// Fixed reset exponents of the two linear registers.
`define SLEW_EXP_RESET 5'h1C
`define DIVIDER_EXP_RESET 5'h19

// Slew exponent that gives one mantissa LSB of 0.0625 mV/us.
`define SLEW_BASE_EXP 4
// Slew range limits in microvolts per microsecond.
`define SLEW_MIN_UV_PER_US 67
`define SLEW_MAX_UV_PER_US 15933
// One slew unit (1/16 mV/us) expressed in tenths of a microvolt per microsecond.
`define SLEW_UNIT_TENTH_UV 625

// Margin field codes taken from the operation command.
`define MARGIN_SEL_NONE 2'h0
`define MARGIN_SEL_LOW 2'h1
`define MARGIN_SEL_HIGH 2'h2

// Output voltage code LSB in microvolts at the default voltage format.
`define VOUT_LSB_UV 1953
// Highest valid target codes for each divider setting at the default format.
`define VALID_MAX_DIV_NONE 16'h0166
`define VALID_MAX_DIV_1TO1 16'h02CC
`define VALID_MAX_DIV_1TO3 16'h0599
`define VALID_MAX_DIV_1TO7 16'h0C00

// Divider decode thresholds, decoded scale in units of 2^-10.
`define DIV_SCALE_FRAC 10
`define DIV_THRESH_EIGHTH 128
`define DIV_THRESH_QUARTER 256
`define DIV_THRESH_HALF 512

// Ramp time base: one step of the slew accumulator each microsecond.
`define CLK_MHZ 125
`define SLEW_TICK_NS 1000
`define SLEW_TICK_CYCLES ((`SLEW_TICK_NS * `CLK_MHZ) / 1000)

`endif

//--- src/setpoint_regs_pkg.sv
package setpoint_regs_pkg;

    // One word command from the bus front end.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_req_t;

    // Values restored from nonvolatile memory at reset or restore.
    typedef struct packed {
        logic [15:0] upper_limit;
        logic [15:0] margin_high;
        logic [15:0] margin_low;
        logic [10:0] slew_mantissa;
        logic [10:0] divider_mantissa;
    } nvm_defaults_t;

    // Sticky status flags presented to the status registers.
    typedef struct packed {
        logic limit_clamp_warning;
        logic none_of_the_above;
        logic word_output_voltage;
        logic invalid_data;
        logic unsupported_command;
    } status_flags_t;

    // Internal feedback divider settings.
    typedef enum logic [1:0] {
        div_none,
        div_1to1,
        div_1to3,
        div_1to7
    } div_setting_t;

endpackage : setpoint_regs_pkg

//--- verification/pmbus_host_model.sv
`timescale 1ns/10ps
module pmbus_host_model (
    output setpoint_regs_pkg::cmd_req_t cmd,
    input wire logic sys_clk,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_error
);
    import setpoint_regs_pkg::*;
    initial cmd = '0;
    // One whole word per command; an idle bus shows the inverse so stale data is not reused.
    task automatic word_xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                             output logic [15:0] rd, output logic err, output logic ok);
        @(posedge sys_clk);
        cmd <= '{1'b1, wr, code, wd};
        @(posedge sys_clk);
        cmd <= '{1'b0, ~wr, ~code, ~wd};
        @(posedge sys_clk);
        ok = rsp_valid;
        rd = rsp_data;
        err = rsp_error;
    endtask : word_xfer
endmodule : pmbus_host_model

//--- verification/setpoint_limit_regs_properties.sv
`timescale 1ns/10ps
module setpoint_limit_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input setpoint_regs_pkg::cmd_req_t cmd,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic conversion_enable,
    input wire logic turn_ramp_active,
    input wire logic clear_faults,
    input wire logic [15:0] output_target,
    input wire logic output_slewing,
    input setpoint_regs_pkg::status_flags_t status,
    input wire logic host_alert
);
    import setpoint_regs_pkg::*;
    // One clock domain, so every check shares the clock and is muted during reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    AST_RSP_LAT: assert property (cmd.valid |=> rsp_valid) else $error("no answer");
    AST_RSP_QUIET: assert property (!cmd.valid |=> !rsp_valid) else $error("stray answer");
    AST_ERR_ALERT: assert property (rsp_error |-> host_alert && (status.invalid_data || status.unsupported_command)) else $error("refusal unflagged");
    AST_WARN_SET: assert property ($rose(status.limit_clamp_warning) |-> status.none_of_the_above && status.word_output_voltage && host_alert) else $error("clamp flags");
    AST_WARN_HOLD: assert property (status.limit_clamp_warning && !clear_faults |=> status.limit_clamp_warning) else $error("warning lost");
    AST_CLAMP_ON: assert property ($rose(status.limit_clamp_warning) |-> $past(conversion_enable)) else $error("clamp while off");
    AST_NO_SLEW: assert property (turn_ramp_active [*3] |-> !output_slewing) else $error("slew on turn ramp");
    // A step larger than one code means the programmed rate was skipped.
    AST_STEP: assert property ((conversion_enable && !turn_ramp_active) [*4] |=> (output_target == $past(output_target)) || (output_target == $past(output_target) + 16'h0001) || (output_target + 16'h0001 == $past(output_target))) else $error("jump");
endmodule : setpoint_limit_checker
bind setpoint_limit_regs setpoint_limit_checker u_chk (.*);

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    import setpoint_regs_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, conversion_enable = 1'b0, turn_ramp_active = 1'b0;
    logic clear_faults = 1'b0, restore_user_all = 1'b0, supply_uvlo_cycle = 1'b0;
    logic [1:0] margin_select = 2'h0;
    logic [15:0] nominal_setpoint = 16'h0040, setpoint_offset = 16'h0000;
    logic [15:0] rsp_data, output_target, rd, lim, sr;
    logic rsp_valid, rsp_error, output_slewing, host_alert, er, ok;
    cmd_req_t cmd;
    div_setting_t divider_setting;
    status_flags_t status;
    nvm_defaults_t nvm = '{16'h0100, 16'h0080, 16'h0040, 11'h020, 11'h010};
    logic [15:0] bad [2] = '{16'hE001, 16'hE0FF};
    int bad_count = 0, total_checks = 0;
    always #4 sys_clk = ~sys_clk;
    // Short tick keeps ramps brief; all ramp waits are bounded anyway.
    setpoint_limit_regs #(.TICK_CYCLES(4)) u_setpoint_limit_regs (.*);
    pmbus_host_model u_pmbus_host_model (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    task automatic xf(input logic wr, input logic [7:0] code, input logic [15:0] wd);
        u_pmbus_host_model.word_xfer(wr, code, wd, rd, er, ok);
        check(ok, 1'b1, "no answer");
    endtask : xf
    // Expected target: active setpoint plus offset, clamped at the upper limit.
    function automatic logic [15:0] tgt(input logic [1:0] s);
        logic [15:0] b;
        b = (s == 2'h2) ? nvm.margin_high : (s == 2'h1) ? nvm.margin_low : nominal_setpoint;
        b = b + setpoint_offset;
        return (b > lim) ? lim : b;
    endfunction : tgt
    task automatic ramp_to(input logic [1:0] s);
        int n;
        margin_select <= s;
        n = 0;
        repeat (3) @(posedge sys_clk);
        while (output_target !== tgt(s) && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : ramp_to
    task automatic pulse_clear();
        clear_faults <= 1'b1;
        @(posedge sys_clk);
        clear_faults <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse_clear
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // A hang counts as a mismatch and ends the run the normal way.
    initial begin
        #700000;
        bad_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(86));
        lim = nvm.upper_limit;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        xf(0, 8'h24, 0); check(rd, 16'h0100, "limit reset");
        xf(0, 8'h25, 0); check(rd, 16'h0080, "high reset");
        xf(0, 8'h26, 0); check(rd, 16'h0040, "low reset");
        xf(0, 8'h27, 0); check(rd, 16'hE020, "slew reset");
        xf(0, 8'h29, 0); check(rd, 16'hC810, "divider reset");
        check(divider_setting, div_1to7, "divider decode");
        $display("test reset done");
        repeat (6) begin
            sr = {5'h1C, 11'(2 + $urandom_range(252))};
            xf(1, 8'h27, sr); check(er, 1'b0, "slew refused");
            xf(0, 8'h27, 0); check(rd, sr, "slew readback");
        end
        foreach (bad[i]) begin
            xf(1, 8'h27, bad[i]); check(er, 1'b0 + 1'b1, "slew range");
            check(status.invalid_data, 1'b1, "invalid flag");
            xf(0, 8'h27, 0); check(rd, sr, "slew kept");
        end
        xf(1, 8'h28, 16'h1234); check(er, 1'b1, "unknown refused");
        check(status.unsupported_command, 1'b1, "unknown code");
        xf(1, 8'h27, 16'hE0FE);
        pulse_clear(); check({status, host_alert}, 6'h00, "clear");
        $display("test slew done");
        conversion_enable <= 1'b1;
        repeat (4) begin
            setpoint_offset <= 16'($urandom_range(15));
            nominal_setpoint <= 16'h0020 + 16'($urandom_range(95));
            ramp_to(2'h2); check(output_target, tgt(2'h2), "margin high");
            ramp_to(2'h1); check(output_target, tgt(2'h1), "margin low");
            ramp_to(2'h0); check(output_target, tgt(2'h0), "nominal");
            ramp_to(2'h3); check(output_target, tgt(2'h3), "code 3");
        end
        $display("test margin done");
        nominal_setpoint <= 16'h0140;
        ramp_to(2'h0); check(output_target, lim, "clamp");
        check({status[4:2], host_alert}, 4'hF, "clamp flags");
        nominal_setpoint <= 16'h0060;
        ramp_to(2'h0);
        pulse_clear();
        lim = 16'h0050;
        xf(1, 8'h24, lim); ramp_to(2'h0); check(output_target, lim, "low limit");
        check({status[4:2], host_alert}, 4'hF, "limit flags");
        xf(1, 8'h25, 16'h0051); check(er, 1'b1, "margin over limit");
        xf(0, 8'h25, 0); check(rd, 16'h0080, "margin kept");
        lim = 16'h0100;
        xf(1, 8'h24, lim);
        $display("test clamp done");
        xf(1, 8'h29, 16'hC880); check(divider_setting, div_1to7, "blocked");
        supply_uvlo_cycle <= 1'b1;
        @(posedge sys_clk);
        supply_uvlo_cycle <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(divider_setting, div_none, "uvlo apply");
        conversion_enable <= 1'b0;
        xf(1, 8'h29, 16'hC840); repeat (2) @(posedge sys_clk);
        check(divider_setting, div_1to1, "direct apply");
        conversion_enable <= 1'b1;
        turn_ramp_active <= 1'b1;
        nominal_setpoint <= 16'h0030;
        repeat (4) @(posedge sys_clk);
        check(output_target, tgt(2'h0), "turn jump");
        check(output_slewing, 1'b0, "turn no slew");
        // A restore brings back the memory slew word and divider setting.
        restore_user_all <= 1'b1;
        @(posedge sys_clk);
        restore_user_all <= 1'b0;
        xf(0, 8'h27, 0); check(rd, 16'hE020, "restore slew");
        check(divider_setting, div_1to7, "restore divider");
        $display("test divider done");
        wrap_up();
    end
endmodule : testbench
